// >>> rsc_cfg.svh
// Constants of the reset source and start-up controller.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_CLK_HZ 20000000
`define RSC_PWRT_TIME_US 64
`define RSC_PWRT_CYC ((`RSC_PWRT_TIME_US * `RSC_CLK_HZ) / 1000000)
`define RSC_WDT_TIME_MS 16
`define RSC_WDT_CYC ((`RSC_WDT_TIME_MS * `RSC_CLK_HZ) / 1000)
`define RSC_OST_CYC 1024
`define RSC_MASTER_CLEAR_PIN_FILT_CYC 4
`define RSC_RST_PULSE_CYC 4
`define RSC_CNT_W 24
`define RSC_ADDR_PULLUP 8'h00
`define RSC_ADDR_CTRL 8'h04
`define RSC_ADDR_CAUSE 8'h08
`define RSC_ADDR_IRQ_STAT 8'h0c
`define RSC_ADDR_IRQ_MASK 8'h10
`define RSC_PULLUP_RST 6'h3f
`define RSC_CTRL_RST 1'h1
`define RSC_CAUSE_POR 5'h07
`define RSC_CAUSE_TO 0
`define RSC_CAUSE_PD 1
`define RSC_CAUSE_RI 2
`define RSC_CAUSE_OVF 3
`define RSC_CAUSE_UNF 4
`define RSC_IRQ_WDT 0
`define RSC_IRQ_RI 1
`define RSC_IRQ_OVF 2
`define RSC_IRQ_UNF 3
`define RSC_IRQ_MASTER_CLEAR_PIN 4
`define RSC_IRQ_START 5
`define RSC_MASTER_CLEAR_PIN_PIN 3
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2
`endif

// >>> rsc_pkg.sv
// Types of the reset source and start-up controller.
`include "rsc_cfg.svh"
package rsc_pkg;
  typedef enum logic [3:0] {
    RSC_ST_START = 4'h1,
    RSC_ST_HOLD = 4'h2,
    RSC_ST_RUN = 4'h4,
    RSC_ST_RST = 4'h8
  } rsc_state_t;

  typedef struct packed {
    rsc_state_t state;
    logic pin_s1;
    logic pin_s2;
    logic master_clear_pin_low;
    logic [7:0] filt_cnt;
    logic prog_d;
    logic [`RSC_CNT_W-1:0] pwrt_cnt;
    logic [`RSC_CNT_W-1:0] ost_cnt;
    logic [`RSC_CNT_W-1:0] wdt_cnt;
    logic [3:0] rst_cnt;
    logic [5:0] pullup_reg;
    logic gpd_n;
    logic [4:0] cause;
    logic [5:0] irq_stat;
    logic [5:0] irq_mask;
    logic irq;
    logic core_reset;
    logic run;
    logic [5:0] pullup_out;
    logic gpio_in;
    logic pin_oe;
    logic awready;
    logic wready;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } rsc_regs_t;
endpackage : rsc_pkg

// >>> rsc_reset_ctrl.sv
// Reset source, master clear filter, start-up sequencer and pull-up control.
//
// Contract
// - Pin reset enabled by either config bit.
// - Low enabled pin holds device in reset.
// - Enabled pin gets internal weak pull-up.
// - Short low pin pulses are filtered out.
// - Reset never drives the pin low.
// - Disabled pin is input, software pull-up.
// - Watchdog expiry without clear resets device.
// - Watchdog reset updates timeout/powerdown flags.
// - Reset instruction resets, clears its flag.
// - Stack errors reset and set flags.
// - Stack resets only when enabled.
// - Programming exit acts as power-on.
// - Power-up timer delays start when enabled.
// - Start needs timers done, pin released.
// - Timers ignore pin; release starts immediately.
// - Six pull-up bits; upper two read zero.
// - Pull-ups need global disable bit cleared; code keeps pin 3 pull-up on while pin reset is enabled.
// - Output pins never get a pull-up; code still pulls up pin 3 when pin reset is enabled.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"
module rsc_reset_ctrl #(
  parameter int PWRT_CYC = `RSC_PWRT_CYC,
  parameter int WDT_CYC = `RSC_WDT_CYC,
  parameter int OST_CYC = `RSC_OST_CYC
) (
  // Clock and power-on reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration word bits and supply events.
  input wire logic cfg_ext_reset_pin_enable,
  input wire logic cfg_low_voltage_program_enable,
  input wire logic cfg_powerup_timer_enable,
  input wire logic cfg_stack_error_reset_enable,
  input wire logic cfg_osc_startup_required,
  input wire logic brownout_reset,
  input wire logic program_mode_active,
  // Core events.
  input wire logic watchdog_clear_instruction,
  input wire logic reset_instruction,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic [5:0] pin_is_output,
  // Master clear pin.
  input wire logic master_clear_pin_i,
  output logic master_clear_pin_o,
  output logic master_clear_pin_oe,
  output logic master_clear_gpio,
  // Core control and pull-ups.
  output logic core_reset,
  output logic core_run,
  output logic [5:0] pullup_en,
  output logic irq,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int CW = `RSC_CNT_W;

  initial begin
    if (PWRT_CYC < 1 || WDT_CYC < 2 || OST_CYC < 1 || PWRT_CYC >= 2**CW || WDT_CYC >= 2**CW
        || OST_CYC >= 2**CW) begin
      $error("rsc_reset_ctrl: count parameter out of range");
    end
  end

  rsc_pkg::rsc_regs_t s;
  rsc_pkg::rsc_regs_t n;
  logic master_clear_pin_en;
  logic master_clear_pin_hold;
  logic prog_exit;
  logic por_evt;
  logic wdt_expire;
  logic stk_ovf_rst;
  logic stk_unf_rst;
  logic pwrt_done;
  logic ost_done;
  logic sw_wr;
  logic [7:0] rd_val;
  logic [1:0] rd_resp;

  // Counter step kept at the counter width.
  function automatic logic [CW-1:0] inc_cnt(input logic [CW-1:0] c);
    inc_cnt = c + {{(CW-1){1'b0}}, 1'b1};
  endfunction : inc_cnt

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  always_comb begin
    n = s;
    master_clear_pin_en = cfg_ext_reset_pin_enable | cfg_low_voltage_program_enable;
    n.pin_s1 = master_clear_pin_i;
    n.pin_s2 = s.pin_s1;
    if (s.pin_s2) begin
      n.filt_cnt = 8'h00;
      n.master_clear_pin_low = 1'b0;
    end else if (s.filt_cnt == 8'(`RSC_MASTER_CLEAR_PIN_FILT_CYC - 1)) begin
      n.master_clear_pin_low = 1'b1;
    end else begin
      n.filt_cnt = s.filt_cnt + 8'h01;
    end
    master_clear_pin_hold = master_clear_pin_en & s.master_clear_pin_low;
    n.prog_d = program_mode_active;
    prog_exit = s.prog_d & ~program_mode_active;
    por_evt = brownout_reset | program_mode_active | prog_exit;
    pwrt_done = ~cfg_powerup_timer_enable || s.pwrt_cnt == CW'(PWRT_CYC);
    ost_done = ~cfg_osc_startup_required || s.ost_cnt == CW'(OST_CYC);
    wdt_expire = s.state == rsc_pkg::RSC_ST_RUN && !watchdog_clear_instruction
                 && s.wdt_cnt == CW'(WDT_CYC - 1);
    stk_ovf_rst = s.state == rsc_pkg::RSC_ST_RUN && stack_overflow && cfg_stack_error_reset_enable;
    stk_unf_rst = s.state == rsc_pkg::RSC_ST_RUN && stack_underflow && cfg_stack_error_reset_enable;

    // Bus write and read decode; software changes go first so hardware sets win.
    sw_wr = s.aw_got && s.w_got && !s.bvalid;
    rd_val = 8'h00;
    rd_resp = `RSC_RESP_OKAY;
    case (s_axi_araddr)
      `RSC_ADDR_PULLUP: rd_val = {2'b00, s.pullup_reg};
      `RSC_ADDR_CTRL: rd_val = {7'h00, s.gpd_n};
      `RSC_ADDR_CAUSE: rd_val = {3'h0, s.cause};
      `RSC_ADDR_IRQ_STAT: rd_val = {2'b00, s.irq_stat};
      `RSC_ADDR_IRQ_MASK: rd_val = {2'b00, s.irq_mask};
      default: rd_resp = `RSC_RESP_SLVERR;
    endcase
    if (s_axi_arvalid && s.arready) begin
      n.rdata = rd_val;
      n.rresp = rd_resp;
      n.rvalid = 1'b1;
      n.arready = 1'b0;
      if (s_axi_araddr == `RSC_ADDR_IRQ_STAT) begin
        n.irq_stat = 6'h00;
      end
    end else if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (s_axi_awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    // Write data has its own ready, so it may arrive before or after the address.
    if (s_axi_wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata[7:0];
      n.w_strb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (sw_wr) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RSC_RESP_OKAY;
      case (s.aw_addr)
        `RSC_ADDR_PULLUP: if (s.w_strb0) n.pullup_reg = s.w_data[5:0];
        `RSC_ADDR_CTRL: if (s.w_strb0) n.gpd_n = s.w_data[0];
        `RSC_ADDR_CAUSE: if (s.w_strb0) n.cause = s.w_data[4:0];
        `RSC_ADDR_IRQ_STAT: n.bresp = `RSC_RESP_OKAY;
        `RSC_ADDR_IRQ_MASK: if (s.w_strb0) n.irq_mask = s.w_data[5:0];
        default: n.bresp = `RSC_RESP_SLVERR;
      endcase
    end

    // -------------------------------------------------------------------
    // Reset sequencer
    // -------------------------------------------------------------------
    case (s.state)
      rsc_pkg::RSC_ST_START: begin
        if (!pwrt_done) n.pwrt_cnt = inc_cnt(s.pwrt_cnt);
        if (!ost_done) n.ost_cnt = inc_cnt(s.ost_cnt);
        if (pwrt_done && ost_done) n.state = rsc_pkg::RSC_ST_HOLD;
      end
      rsc_pkg::RSC_ST_HOLD: begin
        if (!master_clear_pin_hold) begin
          n.state = rsc_pkg::RSC_ST_RUN;
          n.wdt_cnt = '0;
          n.irq_stat[`RSC_IRQ_START] = 1'b1;
        end
      end
      rsc_pkg::RSC_ST_RUN: begin
        n.wdt_cnt = watchdog_clear_instruction ? '0 : inc_cnt(s.wdt_cnt);
        if (master_clear_pin_hold) begin
          n.state = rsc_pkg::RSC_ST_RST;
          n.irq_stat[`RSC_IRQ_MASTER_CLEAR_PIN] = 1'b1;
        end
        if (wdt_expire) begin
          n.state = rsc_pkg::RSC_ST_RST;
          n.cause[`RSC_CAUSE_TO] = 1'b0;
          n.cause[`RSC_CAUSE_PD] = 1'b1;
          n.irq_stat[`RSC_IRQ_WDT] = 1'b1;
        end
        if (reset_instruction) begin
          n.state = rsc_pkg::RSC_ST_RST;
          n.cause[`RSC_CAUSE_RI] = 1'b0;
          n.irq_stat[`RSC_IRQ_RI] = 1'b1;
        end
        if (stk_ovf_rst) begin
          n.state = rsc_pkg::RSC_ST_RST;
          n.cause[`RSC_CAUSE_OVF] = 1'b1;
          n.irq_stat[`RSC_IRQ_OVF] = 1'b1;
        end
        if (stk_unf_rst) begin
          n.state = rsc_pkg::RSC_ST_RST;
          n.cause[`RSC_CAUSE_UNF] = 1'b1;
          n.irq_stat[`RSC_IRQ_UNF] = 1'b1;
        end
        n.rst_cnt = 4'h0;
      end
      rsc_pkg::RSC_ST_RST: begin
        n.rst_cnt = s.rst_cnt + 4'h1;
        if (s.rst_cnt == 4'(`RSC_RST_PULSE_CYC - 1)) n.state = rsc_pkg::RSC_ST_HOLD;
      end
      default: n.state = rsc_pkg::RSC_ST_START;
    endcase
    if (por_evt) begin
      n.state = rsc_pkg::RSC_ST_START;
      n.pwrt_cnt = '0;
      n.ost_cnt = '0;
      n.wdt_cnt = '0;
      n.cause = `RSC_CAUSE_POR;
    end
    n.core_reset = n.state != rsc_pkg::RSC_ST_RUN;
    n.run = n.state == rsc_pkg::RSC_ST_RUN;
    n.irq = |(n.irq_stat & n.irq_mask);

    // -------------------------------------------------------------------
    // Pull-ups and pin
    // -------------------------------------------------------------------
    // global disable, outputs off
    n.pullup_out = s.gpd_n ? 6'h00 : (s.pullup_reg & ~pin_is_output);
    if (master_clear_pin_en) n.pullup_out[`RSC_MASTER_CLEAR_PIN_PIN] = 1'b1;
    n.gpio_in = master_clear_pin_en ? 1'b1 : s.pin_s2;
    n.pin_oe = 1'b0;
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.state <= rsc_pkg::RSC_ST_START;
      s.pin_s1 <= 1'b1;
      s.pin_s2 <= 1'b1;
      s.pullup_reg <= `RSC_PULLUP_RST;
      s.gpd_n <= `RSC_CTRL_RST;
      s.cause <= `RSC_CAUSE_POR;
      s.core_reset <= 1'b1;
      s.gpio_in <= 1'b1;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign master_clear_pin_o = s.pin_oe;
  assign master_clear_pin_oe = s.pin_oe;
  assign master_clear_gpio = s.gpio_in;
  assign core_reset = s.core_reset;
  assign core_run = s.run;
  assign pullup_en = s.pullup_out;
  assign irq = s.irq;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = {24'h000000, s.rdata};
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  a_master_clear_pin_holds_reset: assert property (@(posedge sys_clk) disable iff (rst)
    s.state == rsc_pkg::RSC_ST_RUN && master_clear_pin_hold |=> core_reset ##1 core_reset)
    else $error("held pin did not reset the core");
  a_pin_never_driven: assert property (@(posedge sys_clk) disable iff (rst)
    !master_clear_pin_oe && !master_clear_pin_o)
    else $error("master clear pin driven");
  a_master_clear_pin_pullup_on: assert property (@(posedge sys_clk) disable iff (rst)
    master_clear_pin_en |=> pullup_en[`RSC_MASTER_CLEAR_PIN_PIN])
    else $error("enabled pin lacks pull-up");
  a_filter_min_low: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(s.master_clear_pin_low) |-> !$past(s.pin_s2, 1) && !$past(s.pin_s2, `RSC_MASTER_CLEAR_PIN_FILT_CYC))
    else $error("short pulse passed the filter");
  a_wdt_reset_flags: assert property (@(posedge sys_clk) disable iff (rst)
    wdt_expire && !por_evt |=> s.state == rsc_pkg::RSC_ST_RST && !s.cause[`RSC_CAUSE_TO]
      && s.cause[`RSC_CAUSE_PD] ##1 core_reset)
    else $error("watchdog reset missing");
  a_reset_instr_flag: assert property (@(posedge sys_clk) disable iff (rst)
    s.state == rsc_pkg::RSC_ST_RUN && reset_instruction && !por_evt |=> !s.cause[`RSC_CAUSE_RI] && core_reset)
    else $error("reset instruction not handled");
  a_stack_gated: assert property (@(posedge sys_clk) disable iff (rst)
    s.state == rsc_pkg::RSC_ST_RUN && !cfg_stack_error_reset_enable && !master_clear_pin_hold && !por_evt
      && !wdt_expire && !reset_instruction |=> core_run)
    else $error("stack error reset while disabled");
  a_prog_exit_por: assert property (@(posedge sys_clk) disable iff (rst)
    prog_exit |=> s.state == rsc_pkg::RSC_ST_START && s.cause == `RSC_CAUSE_POR)
    else $error("programming exit not a power-on");
  a_pwrt_delay: assert property (@(posedge sys_clk) disable iff (rst)
    s.state == rsc_pkg::RSC_ST_START && cfg_powerup_timer_enable && s.pwrt_cnt != CW'(PWRT_CYC)
      |=> !core_run)
    else $error("started before power-up timer");
  a_release_starts: assert property (@(posedge sys_clk) disable iff (rst)
    s.state == rsc_pkg::RSC_ST_HOLD && !master_clear_pin_hold && !por_evt |=> core_run)
    else $error("release did not start at once");
  a_output_no_pullup: assert property (@(posedge sys_clk) disable iff (rst)
    pin_is_output[0] |=> !pullup_en[0])
    else $error("pull-up on output pin");
  a_pin_off_no_reset: assert property (@(posedge sys_clk) disable iff (rst)
    s.state == rsc_pkg::RSC_ST_RUN && !master_clear_pin_en && !por_evt && !wdt_expire && !reset_instruction
      && !stk_ovf_rst && !stk_unf_rst |=> core_run)
    else $error("disabled pin reset the core");
  a_gpio_follows_pin: assert property (@(posedge sys_clk) disable iff (rst)
    !master_clear_pin_en |=> master_clear_gpio == $past(s.pin_s2))
    else $error("disabled pin input not passed on");
  a_start_after_hold: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(core_run) |-> $past(s.state == rsc_pkg::RSC_ST_HOLD && !master_clear_pin_hold))
    else $error("start without timers done and pin released");
  a_clear_keeps_run: assert property (@(posedge sys_clk) disable iff (rst)
    s.state == rsc_pkg::RSC_ST_RUN && watchdog_clear_instruction && !por_evt && !master_clear_pin_hold
      && !reset_instruction && !stk_ovf_rst && !stk_unf_rst |=> core_run)
    else $error("watchdog clear did not keep the core running");
  a_global_pullup_off: assert property (@(posedge sys_clk) disable iff (rst)
    s.gpd_n |=> pullup_en[5:4] == 2'b00 && pullup_en[2:0] == 3'b000)
    else $error("pull-up on while globally disabled");
  a_pullup_follows_reg: assert property (@(posedge sys_clk) disable iff (rst)
    !s.gpd_n && !master_clear_pin_en |=> pullup_en == $past(s.pullup_reg & ~pin_is_output))
    else $error("pull-up does not follow its enable bit");
  a_overflow_flag: assert property (@(posedge sys_clk) disable iff (rst)
    stk_ovf_rst && !por_evt |=> s.cause[`RSC_CAUSE_OVF] && core_reset)
    else $error("stack overflow reset missing");
  a_underflow_flag: assert property (@(posedge sys_clk) disable iff (rst)
    stk_unf_rst && !por_evt |=> s.cause[`RSC_CAUSE_UNF] && core_reset)
    else $error("stack underflow reset missing");
  a_pin_two_stage: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst, 1) && !$past(rst, 2) |-> s.pin_s2 == $past(master_clear_pin_i, 2))
    else $error("pin not passed through two stages");
endmodule : rsc_reset_ctrl
`default_nettype wire

// >>> rsc_pin_drv.sv
// External circuit that drives the master clear pin.
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_drv (
  // Clock.
  input wire logic sys_clk,
  // Pin control and pin level.
  input wire logic drive_low,
  input wire logic pull_up,
  output logic pin
);
  logic flt = 1'b0;
  // A released pin with no pull-up floats; it is shown as a toggling level.
  always @(posedge sys_clk) begin
    flt <= ~flt;
  end
  assign pin = drive_low ? 1'b0 : (pull_up ? 1'b1 : flt);
endmodule : rsc_pin_drv
`default_nettype wire

// >>> rsc_reset_ctrl_test.sv
// Self-checking testbench of the reset source and start-up controller.
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl_test;
  localparam int PW = 8;
  logic sys_clk = 0, rst = 1, en_pin = 1, en_lvp = 0, en_pwrt = 1, en_stk = 0, en_osc = 1;
  logic bor = 0, prog = 0, wdclr = 0, kick = 1, low = 0;
  logic [2:0] ev = 0;
  logic [5:0] pout = 0, pullup_en;
  logic pin_i, pin_o, pin_oe, gpio, core_reset, core_run, irq;
  logic [7:0] awaddr = 0, araddr = 0, kc = 0;
  logic [31:0] wdata = 0, rdata, rd, r;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, br, rr;
  int seed = 32'h6f19d319, n_mismatch = 0, samples_checked = 0, cyc_n = 0, n;

  rsc_reset_ctrl #(.PWRT_CYC(PW), .WDT_CYC(16), .OST_CYC(4)) u_rsc_reset_ctrl (
    .sys_clk, .rst, .cfg_ext_reset_pin_enable(en_pin), .cfg_low_voltage_program_enable(en_lvp),
    .cfg_powerup_timer_enable(en_pwrt), .cfg_stack_error_reset_enable(en_stk),
    .cfg_osc_startup_required(en_osc), .brownout_reset(bor), .program_mode_active(prog),
    .watchdog_clear_instruction(wdclr), .reset_instruction(ev[0]), .stack_overflow(ev[1]),
    .stack_underflow(ev[2]), .pin_is_output(pout), .master_clear_pin_i(pin_i),
    .master_clear_pin_o(pin_o), .master_clear_pin_oe(pin_oe), .master_clear_gpio(gpio),
    .core_reset, .core_run, .pullup_en, .irq, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rsc_pin_drv u_rsc_pin_drv (.sys_clk, .drive_low(low), .pull_up(pullup_en[3]), .pin(pin_i));

  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk

  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      done = bvalid;
      br = bresp;
    end
    bready <= 0;
  endtask : wr

  task rdr(input logic [7:0] a);
    logic done;
    done = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 0;
      done = rvalid;
      rd = rdata;
      rr = rresp;
    end
    rready <= 0;
  endtask : rdr

  task start_wait;
    n = 0;
    while (!core_run && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : start_wait

  task ev_pulse(input int b, input logic e);
    @(posedge sys_clk);
    ev[b] <= 1;
    @(posedge sys_clk);
    ev[b] <= 0;
    @(posedge sys_clk);
    chk("core_reset", e, core_reset);
  endtask : ev_pulse

  function automatic logic [31:0] cause_exp(input int k);
    logic [31:0] c;
    c = 32'h07;
    if (k == 0) c[0] = 0;
    if (k == 1) c[2] = 0;
    if (k == 2) c[3] = 1;
    if (k == 3) c[4] = 1;
    return c;
  endfunction : cause_exp

  // Watchdog clear every eight cycles while kick is set.
  always @(posedge sys_clk) begin
    kc <= kc + 8'h01;
    wdclr <= kick && kc[2:0] == 3'h0;
    cyc_n++;
    if (!rst) chk("pin_drive", 0, {pin_o, pin_oe});
    if (cyc_n == 8000) begin
      n_mismatch++;
      print_verdict;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(5);
    chk("run_in_reset", 0, core_run);
    rst <= 0;
    start_wait;
    chk("start_time", 1, n >= PW && n <= PW + 8);
    rdr(8'h00);
    chk("pullup_rst", 32'h3f, rd);
    rdr(8'h04);
    chk("ctrl_rst", 32'h1, rd);
    rdr(8'h08);
    chk("cause_rst", 32'h7, rd);
    rdr(8'h14);
    chk("rresp", 2'h2, rr);
    wr(8'h14, 1);
    chk("bresp", 2'h2, br);
    en_pin <= 0;
    wr(8'h04, 0);
    repeat (6) begin
      r = $random(seed);
      pout <= 6'($random(seed));
      wr(8'h00, r);
      rdr(8'h00);
      chk("pullup_rd", r & 32'h3f, rd);
      chk("pullup_en", r[5:0] & ~pout, pullup_en);
    end
    wr(8'h04, 1);
    cyc(2);
    chk("pullup_off", 0, pullup_en);
    wr(8'h04, 0);
    wr(8'h00, 8'h08);
    pout <= 0;
    low <= 1;
    cyc(20);
    chk("gpio_low", 0, {core_run, gpio} ^ 2'b10);
    low <= 0;
    cyc(6);
    chk("gpio_high", 1, gpio);
    wr(8'h00, 0);
    en_lvp <= 1;
    cyc(2);
    chk("pin_pullup", 6'h08, pullup_en);
    low <= 1;
    cyc(30);
    chk("lvp_reset", 1, core_reset);
    low <= 0;
    start_wait;
    chk("release", 1, n <= 10);
    en_lvp <= 0;
    en_pin <= 1;
    repeat (4) begin
      low <= 1;
      cyc(({$random(seed)} % 3) + 1);
      low <= 0;
      cyc(8);
      chk("short_pulse", 1, core_run);
    end
    low <= 1;
    cyc(10);
    chk("long_pulse", 1, core_reset);
    low <= 0;
    start_wait;
    wr(8'h10, 1);
    rdr(8'h0c);
    kick <= 0;
    n = 0;
    while (!core_reset && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    chk("wdt_fire", 1, core_reset && n >= 8);
    kick <= 1;
    start_wait;
    chk("irq_set", 1, irq);
    rdr(8'h08);
    chk("cause_wdt", cause_exp(0), rd);
    rdr(8'h0c);
    chk("irq_stat", 1, rd[0]);
    cyc(1);
    chk("irq_clr", 0, irq);
    wr(8'h10, 0);
    wstrb <= 4'h0;
    wr(8'h10, 32'h3f);
    wstrb <= 4'hf;
    rdr(8'h10);
    chk("strb_off", 0, rd);
    cyc(60);
    chk("wdt_kicked", 1, core_run);
    for (int k = 0; k < 3; k++) begin
      wr(8'h08, 7);
      en_stk <= 0;
      if (k > 0) ev_pulse(k, 0);
      en_stk <= 1;
      ev_pulse(k, 1);
      start_wait;
      rdr(8'h08);
      chk("cause_ev", cause_exp(k + 1), rd);
    end
    for (int k = 0; k < 3; k++) begin
      wr(8'h08, 0);
      if (k == 2) en_pwrt <= 0;
      if (k == 2) en_osc <= 0;
      if (k == 0) prog <= 1;
      else bor <= 1;
      cyc(5);
      chk("supply_rst", 1, core_reset);
      prog <= 0;
      bor <= 0;
      start_wait;
      chk("supply_start", k < 2, n >= PW);
      rdr(8'h08);
      chk("cause_por", 32'h7, rd);
    end
    en_pwrt <= 1;
    low <= 1;
    bor <= 1;
    cyc(2);
    bor <= 0;
    cyc(40);
    chk("held_low", 0, core_run);
    low <= 0;
    start_wait;
    chk("quick_run", 1, n <= 8);
    print_verdict;
  end
endmodule : rsc_reset_ctrl_test
`default_nettype wire
